// >>> core/fcd_map.svh
`ifndef FCD_MAP_SVH
`define FCD_MAP_SVH
// register offsets of the controller (byte addresses on wishbone)
`define FCD_OFF_CTRL    4'h0
`define FCD_OFF_ADDR    4'h4
`define FCD_OFF_DATA    4'h8
`define FCD_OFF_STAT    4'hc
// command codes, low byte only
`define FCD_CMD_UNL1    8'haa
`define FCD_CMD_UNL2    8'h55
`define FCD_CMD_RESET   8'hf0
`define FCD_CMD_ID      8'h90
`define FCD_CMD_TUNP    8'h77
`define FCD_CMD_PROG    8'ha0
`define FCD_CMD_BYPASS  8'h20
`define FCD_CMD_ERASE   8'h80
`define FCD_CMD_CHIP    8'h10
`define FCD_CMD_SECT    8'h30
`define FCD_CMD_SUSP    8'hb0
`define FCD_CMD_RESUME  8'h30
`define FCD_CMD_CFI     8'h98
`define FCD_CMD_BYPX    8'h00
// unlock and CFI addresses, word and byte mode
`define FCD_A_W555      20'h00555
`define FCD_A_W2AA      20'h002aa
`define FCD_A_B555      20'h00aaa
`define FCD_A_B2AA      20'h00555
`define FCD_A_WCFI      20'h00055
`define FCD_A_BCFI      20'h000aa
// control fields
`define FCD_CTRL_OP_LSB 0
`define FCD_CTRL_BYTE   4
`define FCD_CTRL_GO     31
// status fields
`define FCD_ST_BUSY     0
`define FCD_ST_FAIL     1
`define FCD_ST_BYP      2
// pin cycle timing, in clocks less one: setup, strobe low, recovery
`define FCD_T_SETUP     4'h2
`define FCD_T_STROBE    4'h4
`define FCD_T_HOLD      4'h2
`define FCD_POLL_MAX    24'h0fffff
`endif

// >>> core/fcd_pkg.sv
package fcd_pkg;
  typedef enum logic [3:0] {
    FCD_OP_RESET  = 4'h0,
    FCD_OP_ID     = 4'h1,
    FCD_OP_TUNP   = 4'h2,
    FCD_OP_PROG   = 4'h3,
    FCD_OP_BYPENT = 4'h4,
    FCD_OP_BYPPRG = 4'h5,
    FCD_OP_BYPEXT = 4'h6,
    FCD_OP_CHIP   = 4'h7,
    FCD_OP_SECT   = 4'h8,
    FCD_OP_SUSP   = 4'h9,
    FCD_OP_RESUME = 4'ha,
    FCD_OP_CFI    = 4'hb,
    FCD_OP_READ   = 4'hc
  } fcd_op_t;
  typedef enum logic [2:0] {
    FCD_IDLE  = 3'b000,
    FCD_SETUP = 3'b001,
    FCD_STRB  = 3'b011,
    FCD_HOLD  = 3'b010,
    FCD_NEXT  = 3'b110,
    FCD_POLL  = 3'b111
  } fcd_state_t;
  typedef struct packed {
    logic        we;
    logic [19:0] addr;
    logic [15:0] data;
  } fcd_cycle_t;
  typedef struct packed {
    logic        busy;
    logic        fail;
    logic        bypass;
  } fcd_status_t;
endpackage

// >>> core/fcd_host.sv
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
`include "fcd_map.svh"
module fcd_host
  import fcd_pkg::*;
(
  input  wire logic        CLOCK,      // 50 MHz
  input  wire logic        ARST_N,     // async reset, low
  input  wire logic        CLK_EN,     // freezes state when low
  input  wire logic        WB_CYC_I,   // wishbone cycle
  input  wire logic        WB_STB_I,   // wishbone strobe
  input  wire logic        WB_WE_I,    // wishbone write
  input  wire logic [3:0]  WB_ADR_I,   // byte address
  input  wire logic [3:0]  WB_SEL_I,   // byte lanes
  input  wire logic [31:0] WB_DAT_I,   // write data
  output logic      [31:0] WB_DAT_O,   // read data
  output logic             WB_ACK_O,   // acknowledge
  output logic      [19:0] F_ADDR,     // flash address
  input  wire logic [15:0] F_DQ_I,     // flash data in
  output logic      [15:0] F_DQ_O,     // flash data out
  output logic      [15:0] F_DQ_OE_N,  // low while driving
  output logic             F_CE_N,     // chip enable
  output logic             F_WE_N,     // write strobe
  output logic             F_OE_N      // output enable
);
  // ---------------------------------------------------------------
  // sequence table
  // ---------------------------------------------------------------
  // returns cycle i of an op; last flags the final step
  function automatic fcd_cycle_t step(input fcd_op_t op, input logic [2:0] i,
                                      input logic bm, input logic [19:0] a,
                                      input logic [15:0] d, output logic last);
    logic [19:0] u1, u2, ba;
    fcd_cycle_t  c;
    u1 = bm ? `FCD_A_B555 : `FCD_A_W555;
    u2 = bm ? `FCD_A_B2AA : `FCD_A_W2AA;
    ba = {a[19:12], 12'h000};
    c  = '{we: 1'b1, addr: u1, data: {8'h00, `FCD_CMD_UNL1}};
    last = 1'b0;
    if (i == 3'd1) c = '{we: 1'b1, addr: u2, data: {8'h00, `FCD_CMD_UNL2}};
    case (op)
      FCD_OP_RESET, FCD_OP_SUSP, FCD_OP_RESUME, FCD_OP_CFI: begin
        last = 1'b1;
        c.addr = (op == FCD_OP_SUSP) ? ba : 20'h00000;
        c.data[7:0] = (op == FCD_OP_RESET) ? `FCD_CMD_RESET :
                      (op == FCD_OP_SUSP)  ? `FCD_CMD_SUSP  :
                      (op == FCD_OP_RESUME) ? `FCD_CMD_RESUME : `FCD_CMD_CFI;
        if (op == FCD_OP_CFI) c.addr = bm ? `FCD_A_BCFI : `FCD_A_WCFI;
      end
      FCD_OP_READ: begin
        last = 1'b1;
        c = '{we: 1'b0, addr: a, data: 16'h0000};
      end
      FCD_OP_ID, FCD_OP_TUNP, FCD_OP_PROG, FCD_OP_BYPENT: begin
        if (i == 3'd2) begin
          c.addr = ba | u1;
          c.data[7:0] = (op == FCD_OP_ID)   ? `FCD_CMD_ID   :
                        (op == FCD_OP_TUNP) ? `FCD_CMD_TUNP :
                        (op == FCD_OP_PROG) ? `FCD_CMD_PROG : `FCD_CMD_BYPASS;
          last = (op == FCD_OP_TUNP) || (op == FCD_OP_BYPENT);
        end else if (i == 3'd3) begin
          last = 1'b1;
          if (op == FCD_OP_ID) c = '{we: 1'b0, addr: a, data: 16'h0000};
          else c = '{we: 1'b1, addr: a, data: d};
        end
      end
      FCD_OP_BYPPRG, FCD_OP_BYPEXT: begin
        last = (i == 3'd1);
        c.addr = 20'h00000;
        if (i == 3'd0)
          c.data = {8'h00, (op == FCD_OP_BYPPRG) ? `FCD_CMD_PROG : `FCD_CMD_ID};
        else if (op == FCD_OP_BYPPRG) c = '{we: 1'b1, addr: a, data: d};
        else c.data = {8'h00, `FCD_CMD_BYPX};
      end
      FCD_OP_CHIP, FCD_OP_SECT: begin
        if (i == 3'd2) c.data[7:0] = `FCD_CMD_ERASE;
        if (i == 3'd3) c.addr = u1;
        if (i == 3'd4) c = '{we: 1'b1, addr: u2, data: {8'h00, `FCD_CMD_UNL2}};
        if (i == 3'd5) begin
          last = 1'b1;
          c.addr = (op == FCD_OP_SECT) ? ba : u1;
          c.data[7:0] = (op == FCD_OP_SECT) ? `FCD_CMD_SECT : `FCD_CMD_CHIP;
        end
      end
      default: last = 1'b1;
    endcase
    return c;
  endfunction

  // ---------------------------------------------------------------
  // registers and sequencer
  // ---------------------------------------------------------------
  fcd_state_t  st_q, st_d;
  fcd_op_t     op_q, op_d;
  logic [2:0]  idx_q, idx_d;
  logic [3:0]  tmr_q, tmr_d;
  logic [23:0] pc_q, pc_d;
  logic        bm_q, bm_d, poll_q, poll_d;
  logic [19:0] a_q, a_d, fa_q, fa_d;
  logic [15:0] d_q, d_d, rd_q, rd_d, fo_q, fo_d;
  fcd_status_t s_q, s_d;
  logic        ce_q, ce_d, we_q, we_d, oe_q, oe_d, oen_q, oen_d;
  logic [31:0] wdo_q, wdo_d;
  logic        ack_q, ack_d;
  fcd_cycle_t  cur;
  logic        lst, req;

  assign req = WB_CYC_I && WB_STB_I && !ack_q;

  always_comb begin
    st_d = st_q;
    op_d = op_q;
    idx_d = idx_q;
    tmr_d = tmr_q;
    pc_d = pc_q;
    bm_d = bm_q;
    poll_d = poll_q;
    a_d = a_q;
    d_d = d_q;
    rd_d = rd_q;
    s_d = s_q;
    ce_d = ce_q;
    we_d = we_q;
    oe_d = oe_q;
    oen_d = oen_q;
    fa_d = fa_q;
    fo_d = fo_q;
    wdo_d = wdo_q;
    ack_d = 1'b0;
    cur = step(op_q, idx_q, bm_q, a_q, d_q, lst);
    if (req) begin
      ack_d = 1'b1;
      wdo_d = 32'h00000000;
      case (WB_ADR_I)
        `FCD_OFF_CTRL: begin
          wdo_d = {27'h0000000, bm_q, op_q};
          if (WB_WE_I && WB_SEL_I[0]) bm_d = WB_DAT_I[`FCD_CTRL_BYTE];
          if (WB_WE_I && WB_SEL_I[3] && WB_DAT_I[`FCD_CTRL_GO] && st_q == FCD_IDLE) begin
            op_d = fcd_op_t'(WB_DAT_I[`FCD_CTRL_OP_LSB +: 4]);
            poll_d = WB_DAT_I[`FCD_CTRL_OP_LSB +: 4] inside {4'h3, 4'h5, 4'h7, 4'h8};
            idx_d = 3'd0;
            tmr_d = `FCD_T_SETUP;
            st_d = FCD_SETUP;
            s_d.busy = 1'b1;
            s_d.fail = 1'b0;
          end
        end
        `FCD_OFF_ADDR: begin
          wdo_d = {12'h000, a_q};
          if (WB_WE_I && st_q == FCD_IDLE) a_d = WB_DAT_I[19:0];
        end
        `FCD_OFF_DATA: begin
          wdo_d = {16'h0000, rd_q};
          if (WB_WE_I && st_q == FCD_IDLE) d_d = WB_DAT_I[15:0];
        end
        `FCD_OFF_STAT: begin
          // placed bit by bit: the struct order differs from the status map
          wdo_d[`FCD_ST_BUSY] = s_q.busy;
          wdo_d[`FCD_ST_FAIL] = s_q.fail;
          wdo_d[`FCD_ST_BYP]  = s_q.bypass;
        end
        default: wdo_d = 32'h00000000;
      endcase
    end
    case (st_q)
      FCD_IDLE: ;
      FCD_SETUP: begin
        fa_d = cur.addr;
        fo_d = cur.data;
        oen_d = !cur.we;
        ce_d = 1'b0;
        if (tmr_q == 4'h0) begin
          we_d = !cur.we;
          oe_d = cur.we;
          tmr_d = `FCD_T_STROBE;
          st_d = FCD_STRB;
        end else tmr_d = tmr_q - 4'h1;
      end
      FCD_STRB: begin
        if (tmr_q == 4'h0) begin
          if (!cur.we) rd_d = F_DQ_I;
          we_d = 1'b1;
          oe_d = 1'b1;
          tmr_d = `FCD_T_HOLD;
          st_d = FCD_HOLD;
        end else tmr_d = tmr_q - 4'h1;
      end
      FCD_HOLD: begin
        if (tmr_q == 4'h0) begin
          ce_d = 1'b1;
          oen_d = 1'b1;
          st_d = FCD_NEXT;
        end else tmr_d = tmr_q - 4'h1;
      end
      FCD_NEXT: begin
        tmr_d = `FCD_T_SETUP;
        if (!lst) begin
          idx_d = idx_q + 3'd1;
          st_d = FCD_SETUP;
        end else if (poll_q) begin
          // limit and index are loaded once; later status reads pass through
          if (op_q != FCD_OP_READ) begin
            pc_d = `FCD_POLL_MAX;
            op_d = FCD_OP_READ;
            idx_d = 3'd0;
          end
          // erase is done when the polling bit reads 1, whatever data was given
          if (op_q inside {FCD_OP_CHIP, FCD_OP_SECT}) d_d[7] = 1'b1;
          st_d = FCD_POLL;
        end else begin
          if (op_q == FCD_OP_BYPENT) s_d.bypass = 1'b1;
          if (op_q inside {FCD_OP_BYPEXT, FCD_OP_RESET}) s_d.bypass = 1'b0;
          s_d.busy = 1'b0;
          st_d = FCD_IDLE;
        end
      end
      FCD_POLL: begin
        // one status read per pass; the target bit is d_q[7]
        // polling simply waits out device time-outs
        if (idx_q == 3'd1 && rd_q[7] == d_q[7]) begin
          // one more read, as the other bits may still lag the polling bit
          poll_d = 1'b0;
          st_d = FCD_SETUP;
        end else if (pc_q == 24'h000000) begin
          s_d.fail = 1'b1;
          s_d.busy = 1'b0;
          st_d = FCD_IDLE;
        end else begin
          pc_d = pc_q - 24'h000001;
          idx_d = 3'd1;
          poll_d = 1'b1;
          st_d = FCD_SETUP;
        end
      end
      default: st_d = FCD_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q <= FCD_IDLE;
      op_q <= FCD_OP_RESET;
      idx_q <= 3'd0;
      tmr_q <= 4'h0;
      pc_q <= 24'h000000;
      bm_q <= 1'b0;
      poll_q <= 1'b0;
      a_q <= 20'h00000;
      d_q <= 16'h0000;
      rd_q <= 16'h0000;
      s_q <= '0;
      ce_q <= 1'b1;
      we_q <= 1'b1;
      oe_q <= 1'b1;
      oen_q <= 1'b1;
      fa_q <= 20'h00000;
      fo_q <= 16'h0000;
      wdo_q <= 32'h00000000;
      ack_q <= 1'b0;
    end else if (CLK_EN) begin
      st_q <= st_d;
      op_q <= op_d;
      idx_q <= idx_d;
      tmr_q <= tmr_d;
      pc_q <= pc_d;
      bm_q <= bm_d;
      poll_q <= poll_d;
      a_q <= a_d;
      d_q <= d_d;
      rd_q <= rd_d;
      s_q <= s_d;
      ce_q <= ce_d;
      we_q <= we_d;
      oe_q <= oe_d;
      oen_q <= oen_d;
      fa_q <= fa_d;
      fo_q <= fo_d;
      wdo_q <= wdo_d;
      ack_q <= ack_d;
    end
  end

  assign WB_DAT_O  = wdo_q;
  assign WB_ACK_O  = ack_q;
  assign F_ADDR    = fa_q;
  assign F_DQ_O    = fo_q;
  assign F_DQ_OE_N = {16{oen_q}};
  assign F_CE_N    = ce_q;
  assign F_WE_N    = we_q;
  assign F_OE_N    = oe_q;
endmodule // fcd_host

// >>> bench/fcd_host_asserts.sv
`timescale 1ns/100ps
module fcd_host_asserts (
  input wire logic        CLOCK,      // clock
  input wire logic        ARST_N,     // async reset, low
  input wire logic        WB_STB_I,   // bus strobe
  input wire logic        WB_CYC_I,   // bus cycle
  input wire logic        WB_ACK_O,   // bus acknowledge
  input wire logic [19:0] F_ADDR,     // flash address
  input wire logic [15:0] F_DQ_O,     // flash data out
  input wire logic [15:0] F_DQ_OE_N,  // low while driving
  input wire logic        F_CE_N,     // chip enable
  input wire logic        F_WE_N,     // write strobe
  input wire logic        F_OE_N      // output enable
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!ARST_N);
  sequence s_wr_strobe;
    !F_WE_N [*5] ##1 F_WE_N;
  endsequence
  sequence s_held;
    ($stable(F_ADDR) && $stable(F_DQ_O)) [*5];
  endsequence
  chk_ack_reply: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack not one cycle after request");
  chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  chk_ack_idle: assert property (!WB_STB_I |=> !WB_ACK_O)
    else $error("ack without request");
  chk_we_with_ce: assert property (!F_WE_N |-> !F_CE_N)
    else $error("write strobe without chip enable");
  chk_no_overlap: assert property (!(!F_WE_N && !F_OE_N))
    else $error("write and read strobes together");
  chk_write_drive: assert property (!F_WE_N |-> F_DQ_OE_N == 16'h0000)
    else $error("data bus not driven during write");
  chk_read_release: assert property (!F_OE_N |-> F_DQ_OE_N == 16'hffff)
    else $error("data bus driven during read");
  chk_strobe_width: assert property ($fell(F_WE_N) |-> s_wr_strobe)
    else $error("write strobe width wrong");
  chk_addr_hold: assert property ($fell(F_WE_N) |-> s_held)
    else $error("address or data moved under strobe");
endmodule // fcd_host_asserts

// >>> bench/fcd_flash_model.sv
`timescale 1ns/100ps
module fcd_flash_model #(
  parameter logic [15:0] MAKER = 16'h005a  // arbitrary identity value
) (
  input  wire logic        CE_N,  // chip enable
  input  wire logic        WE_N,  // write strobe
  input  wire logic        OE_N,  // output enable
  input  wire logic [19:0] ADDR,  // address
  input  wire logic [15:0] DQ,    // resolved bus
  output logic      [15:0] DOUT   // device drive
);
  logic [15:0] mem [logic [19:0]];
  logic [15:0] val, hold, pd;
  logic [19:0] pa;
  int          step = 0;
  bit          byp, idm, ers, busy, prg;
  logic [7:0]  lcmd;   // low byte of the last write, for the bench
  logic [19:0] laddr;  // latched address of that write
  always @(negedge WE_N) if (!CE_N) pa = ADDR;
  // writes arriving while an algorithm runs are dropped, as the device ignores them
  always @(posedge WE_N) if (!CE_N) begin
    pd = DQ;
    lcmd = DQ[7:0];
    laddr = pa;
    if (DQ[7:0] == 8'hf0 && !byp) begin
      step = 0;
      idm = 0;
    end else case (step)
      0: step = byp ? ((DQ[7:0] == 8'ha0) ? 4 : (DQ[7:0] == 8'h90) ? 6 : 0)
              : int'(DQ[7:0] == 8'haa && pa[10:0] == 11'h555);
      1: step = (DQ[7:0] == 8'h55 && pa[10:0] == 11'h2aa) ? 2 : 0;
      2: begin
        if (ers && DQ[7:0] == 8'h10) begin
          busy = 1;
          #4000 mem.delete();
          busy = 0;
        end
        // the latched word, as the bus has moved on after an erase delay
        ers = (pd[7:0] == 8'h80);
        idm = (pd[7:0] == 8'h90);
        byp = (pd[7:0] == 8'h20);
        step = (pd[7:0] == 8'ha0) ? 4 : 0;
      end
      4: begin
        step = 0;
        {busy, prg} = 2'b11;
        #2000 mem[pa] = pd;
        {busy, prg} = 2'b00;
      end
      6: begin
        step = 0;
        byp = (DQ[7:0] != 8'h00);
      end
      default: step = 0;
    endcase
  end
  always @* begin
    if (busy) val = prg ? {8'h00, ~pd[7], 7'h00} : 16'h0000;
    else if (idm) val = (ADDR[7:0] == 8'h00) ? MAKER : 16'h0000;
    else val = mem.exists(ADDR) ? mem[ADDR] : 16'hffff;
    if (!CE_N && !OE_N) hold = val;
  end
  // a released bus shows the inverse of the last value, never a stale copy
  assign DOUT = (!CE_N && !OE_N) ? val : ~hold;
endmodule // fcd_flash_model

// >>> bench/tb.sv
`timescale 1ns/100ps
`include "fcd_map.svh"
module tb;
  import fcd_pkg::*;
  localparam logic [15:0] MAKER = 16'h005a;  // arbitrary identity value
  logic        clock, arst_n, cyc, stb, we, ack, ce_n, we_n, oe_n, bmode;
  logic [3:0]  adr;
  logic [31:0] dat, rdat, wb_dat;
  logic [19:0] f_addr;
  logic [15:0] dq_o, dq_oe_n, fdout;
  wire  [15:0] dq = (dq_o & ~dq_oe_n) | (fdout & dq_oe_n);
  int          error_cnt, samples_checked, cycle_cnt;
  fcd_host u_dut (.CLOCK(clock), .ARST_N(arst_n), .CLK_EN(1'b1), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat),
    .WB_DAT_O(wb_dat), .WB_ACK_O(ack), .F_ADDR(f_addr), .F_DQ_I(dq), .F_DQ_O(dq_o),
    .F_DQ_OE_N(dq_oe_n), .F_CE_N(ce_n), .F_WE_N(we_n), .F_OE_N(oe_n));
  fcd_flash_model #(.MAKER(MAKER)) u_flash (.CE_N(ce_n), .WE_N(we_n), .OE_N(oe_n),
    .ADDR(f_addr), .DQ(dq), .DOUT(fdout));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    // no answer time is assumed; only the bench timeout ends this wait
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    rdat = wb_dat;
    {cyc, stb, we} <= 3'b000;
    @(posedge clock);
  endtask
  // runs one operation and leaves the final status word in rdat
  task automatic op(input fcd_op_t o, input logic [19:0] a, input logic [15:0] d);
    wb(1'b1, `FCD_OFF_ADDR, {12'h000, a});
    wb(1'b1, `FCD_OFF_DATA, {16'h0000, d});
    wb(1'b1, `FCD_OFF_CTRL, {1'b1, 26'h0, bmode, o});
    do begin
      wb(1'b0, `FCD_OFF_STAT, 32'h0);
    end while (rdat[`FCD_ST_BUSY] !== 1'b0);
  endtask
  task automatic read_at(input logic [19:0] a, input logic [15:0] exp);
    op(FCD_OP_READ, a, 16'h0000);
    wb(1'b0, `FCD_OFF_DATA, 32'h0);
    check({16'h0000, rdat[15:0]}, {16'h0000, exp});
  endtask
  task automatic t_reset();
    wb(1'b0, `FCD_OFF_STAT, 32'h0);
    check({29'h0, rdat[2:0]}, 32'h0);
    check({28'h0, ce_n, we_n, oe_n, dq_oe_n[0]}, 32'h0000000f);
    wb(1'b0, 4'h2, 32'h0);
    check(rdat, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_program();
    op(FCD_OP_PROG, 20'h12345, 16'ha5c5);
    check({31'h0, rdat[1]}, 32'h0);
    wb(1'b0, `FCD_OFF_DATA, 32'h0);
    check({16'h0000, rdat[15:0]}, 32'h0000a5c5);
    read_at(20'h12345, 16'ha5c5);
    op(FCD_OP_PROG, 20'h00400, 16'h0035);
    read_at(20'h00400, 16'h0035);
    $display("test program done");
  endtask
  task automatic t_ident();
    op(FCD_OP_ID, 20'h3f000, 16'h0000);
    wb(1'b0, `FCD_OFF_DATA, 32'h0);
    check({16'h0000, rdat[15:0]}, {16'h0000, MAKER});
    op(FCD_OP_RESET, 20'h00000, 16'h0000);
    read_at(20'h12345, 16'ha5c5);
    $display("test ident done");
  endtask
  task automatic t_bypass();
    op(FCD_OP_BYPENT, 20'h00000, 16'h0000);
    check({31'h0, rdat[2]}, 32'h1);
    op(FCD_OP_BYPPRG, 20'h00100, 16'h1234);
    op(FCD_OP_BYPEXT, 20'h00000, 16'h0000);
    check({31'h0, rdat[2]}, 32'h0);
    read_at(20'h00100, 16'h1234);
    $display("test bypass done");
  endtask
  task automatic t_erase();
    op(FCD_OP_CHIP, 20'h00000, 16'h0000);
    check({31'h0, rdat[1]}, 32'h0);
    read_at(20'h12345, 16'hffff);
    $display("test erase done");
  endtask
  // the far side records the last write, so command bytes and addresses are seen
  task automatic t_misc();
    op(FCD_OP_TUNP, 20'h00000, 16'h0000);
    check({24'h0, u_flash.lcmd}, {24'h0, `FCD_CMD_TUNP});
    op(FCD_OP_CFI, 20'h00000, 16'h0000);
    check({12'h0, u_flash.laddr}, {12'h0, `FCD_A_WCFI});
    check({24'h0, u_flash.lcmd}, {24'h0, `FCD_CMD_CFI});
    op(FCD_OP_SUSP, 20'h3f123, 16'h0000);
    check({12'h0, u_flash.laddr}, 32'h0003f000);
    check({24'h0, u_flash.lcmd}, {24'h0, `FCD_CMD_SUSP});
    op(FCD_OP_RESUME, 20'h00000, 16'h0000);
    check({24'h0, u_flash.lcmd}, {24'h0, `FCD_CMD_RESUME});
    bmode = 1'b1;
    op(FCD_OP_CFI, 20'h00000, 16'h0000);
    check({12'h0, u_flash.laddr}, {12'h0, `FCD_A_BCFI});
    op(FCD_OP_TUNP, 20'h00000, 16'h0000);
    check({12'h0, u_flash.laddr}, {12'h0, `FCD_A_B555});
    bmode = 1'b0;
    op(FCD_OP_RESET, 20'h00000, 16'h0000);
    check({24'h0, u_flash.lcmd}, {24'h0, `FCD_CMD_RESET});
    read_at(20'h00400, 16'hffff);
    $display("test misc done");
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // ceiling sized well above the under two thousand cycles the tests need
  always @(posedge clock) begin
    cycle_cnt++;
    if (cycle_cnt == 60000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    {arst_n, cyc, stb, we, adr, dat, bmode} = '0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    t_reset();
    t_program();
    t_ident();
    t_bypass();
    t_erase();
    t_misc();
    final_report();
  end
endmodule // tb
bind fcd_host fcd_host_asserts u_chk (.CLOCK, .ARST_N, .WB_STB_I, .WB_CYC_I, .WB_ACK_O,
  .F_ADDR, .F_DQ_O, .F_DQ_OE_N, .F_CE_N, .F_WE_N, .F_OE_N);
